// ===== power_switch_wake_controller.sv
// Power-state controller: tracks system power state, acts on switch presses,
// operating system commands and wake events.
// Assumes standby power and a 50 MHz standby clock; all inputs synchronous.
`include "pswc_params.svh"
module power_switch_wake_controller
	import pswc_pkg::*;
#(
	parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
	parameter int LONG_CYC = `LONG_PRESS_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_standby_ok,
	input wire logic i_switch,
	input wire logic [2:0] i_os_cmd,
	input wire logic i_s5_wake_en,
	input wire logic i_pme_en,
	input wire logic i_lan_wake,
	input wire logic i_pme_wake,
	input wire logic i_rtc_wake,
	input wire logic i_serial_wake,
	input wire logic i_usb_wake,
	input wire logic i_ps2_wake,
	input wire logic i_ps2_alt_prtscr,
	output logic [2:0] o_pstate,
	output logic o_main_power,
	output logic o_cpu_power,
	output logic o_cold_boot,
	output logic o_wake_pulse,
	output logic o_sleep_req
);
	pstate_t st_reg, st_next; // Current power state.
	logic main_reg, main_next; // Main supply enable.
	logic cpu_reg, cpu_next; // Processor supply enable.
	logic cold_reg, cold_next; // One-cycle cold boot request.
	logic wake_reg, wake_next; // One-cycle accepted wake.
	logic sreq_reg, sreq_next; // One-cycle request to the OS to sleep.
	logic s5en_reg, s5en_next; // Captured S5 wake option.
	logic sw_short, sw_long; // Classified presses.
	logic [`WAKE_N-1:0] ok_vec; // Wake sources allowed now.
	logic wake_any;
	os_cmd_t cmd;

	assign cmd = os_cmd_t'(i_os_cmd);

	// The press timer owns switch debounce and duration.
	press_timer #(
		.DEBOUNCE_CYC(DEBOUNCE_CYC),
		.LONG_CYC(LONG_CYC)
	) u_press (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_sw(i_switch),
		.o_short(sw_short),
		.o_long(sw_long)
	);

	// Qualify each wake source against the state; unqualified events vanish.
	always_comb begin
		ok_vec = '0;
		unique case (st_reg)
			PST_S1: begin
				ok_vec[`WSRC_LAN] = i_lan_wake;
				ok_vec[`WSRC_PME] = i_pme_wake & i_pme_en;
				ok_vec[`WSRC_SWITCH] = sw_short;
				ok_vec[`WSRC_PS2] = i_ps2_wake;
			end
			PST_S3: begin
				ok_vec[`WSRC_LAN] = i_lan_wake;
				ok_vec[`WSRC_PME] = i_pme_wake & i_pme_en;
				ok_vec[`WSRC_SWITCH] = sw_short;
				ok_vec[`WSRC_RTC] = i_rtc_wake;
				ok_vec[`WSRC_SERIAL] = i_serial_wake;
				ok_vec[`WSRC_USB] = i_usb_wake;
				ok_vec[`WSRC_PS2] = i_ps2_wake;
			end
			PST_S4: begin
				ok_vec[`WSRC_LAN] = i_lan_wake;
				ok_vec[`WSRC_PME] = i_pme_wake & i_pme_en;
				ok_vec[`WSRC_SWITCH] = sw_short;
				ok_vec[`WSRC_RTC] = i_rtc_wake;
				ok_vec[`WSRC_PS2] = i_ps2_alt_prtscr;
			end
			PST_S5: begin
				// LAN and PME from soft-off need the option, off after reset.
				ok_vec[`WSRC_LAN] = i_lan_wake & s5en_reg;
				ok_vec[`WSRC_PME] = i_pme_wake & i_pme_en & s5en_reg;
				ok_vec[`WSRC_SWITCH] = sw_short;
				ok_vec[`WSRC_RTC] = i_rtc_wake;
				ok_vec[`WSRC_PS2] = i_ps2_alt_prtscr;
			end
			default: begin
				ok_vec = '0;
			end
		endcase
	end
	assign wake_any = |ok_vec;

	// State transitions: OS commands, presses and qualified wakes.
	always_comb begin
		st_next = st_reg;
		cold_next = 1'b0;
		wake_next = 1'b0;
		sreq_next = 1'b0;
		s5en_next = i_s5_wake_en;
		if (!i_standby_ok) begin
			// Without standby supply nothing is processed.
			st_next = PST_G3;
		end else begin
			unique case (st_reg)
				PST_G3: begin
					// Supply returns: settle in soft-off.
					st_next = PST_S5;
				end
				PST_S0: begin
					if (sw_long) begin
						st_next = PST_S5;
					end else if (sw_short) begin
						sreq_next = 1'b1;
						st_next = PST_S3;
					end else begin
						unique case (cmd)
							CMD_S1: st_next = PST_S1;
							CMD_S3: st_next = PST_S3;
							CMD_S4: st_next = PST_S4;
							CMD_S5: st_next = PST_S5;
							default: st_next = PST_S0;
						endcase
					end
				end
				default: begin
					// Sleeping or soft-off: long press forces soft-off.
					if (sw_long) begin
						st_next = PST_S5;
					end else if (wake_any) begin
						st_next = PST_S0;
						wake_next = 1'b1;
						// Leaving soft-off has no saved context.
						cold_next = (st_reg == PST_S5);
					end
				end
			endcase
		end
	end

	// Supply outputs follow the next state so they change with it.
	always_comb begin
		main_next = (st_next == PST_S0) || (st_next == PST_S1);
		cpu_next = main_next;
	end

	// Registers only.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st_reg <= PST_G3;
			main_reg <= 1'b0;
			cpu_reg <= 1'b0;
			cold_reg <= 1'b0;
			wake_reg <= 1'b0;
			sreq_reg <= 1'b0;
			s5en_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			main_reg <= main_next;
			cpu_reg <= cpu_next;
			cold_reg <= cold_next;
			wake_reg <= wake_next;
			sreq_reg <= sreq_next;
			s5en_reg <= s5en_next;
		end
	end

	assign o_pstate = st_reg;
	assign o_main_power = main_reg;
	assign o_cpu_power = cpu_reg;
	assign o_cold_boot = cold_reg;
	assign o_wake_pulse = wake_reg;
	assign o_sleep_req = sreq_reg;
endmodule

// ===== pswc_params.svh
// Constants for the power switch and wake controller.
// Assumes a 50 MHz standby clock; included by the package and the design modules.
`ifndef PSWC_PARAMS_SVH
`define PSWC_PARAMS_SVH
`define CLK_HZ 50000000
`define LONG_PRESS_SEC 4
`define LONG_PRESS_CYC (`CLK_HZ * `LONG_PRESS_SEC)
`define DEBOUNCE_NS 10000000
`define DEBOUNCE_CYC ((`DEBOUNCE_NS / 20))
`define PST_W 3
`define WAKE_N 7
`define WSRC_LAN 0
`define WSRC_PME 1
`define WSRC_SWITCH 2
`define WSRC_RTC 3
`define WSRC_SERIAL 4
`define WSRC_USB 5
`define WSRC_PS2 6
`endif

// ===== pswc_pkg.sv
// Types shared by the power switch and wake controller.
// Assumes pswc_params.svh is on the include path.
`include "pswc_params.svh"
package pswc_pkg;
	// System power states, binary codes written out.
	typedef enum logic [2:0] {
		PST_G3 = 3'h0,
		PST_S0 = 3'h1,
		PST_S1 = 3'h2,
		PST_S3 = 3'h3,
		PST_S4 = 3'h4,
		PST_S5 = 3'h5
	} pstate_t;
	// Operating system commands.
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_S1 = 3'h1,
		CMD_S3 = 3'h2,
		CMD_S4 = 3'h3,
		CMD_S5 = 3'h4
	} os_cmd_t;
endpackage

// ===== press_timer.sv
// Debounces the front-panel switch and classifies each press as short or long.
// Assumes the switch input is synchronous to the clock and active high.
`include "pswc_params.svh"
module press_timer #(
	parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
	parameter int LONG_CYC = `LONG_PRESS_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_sw,
	output logic o_short,
	output logic o_long
);
	logic stable_reg, stable_next; // Debounced switch level.
	logic [31:0] db_reg, db_next; // Debounce settle counter.
	logic [31:0] hold_reg, hold_next; // Press length counter.
	logic fired_reg, fired_next; // Long action already given for this press.
	logic short_reg, short_next;
	logic long_reg, long_next;

	// The debounced level only moves once the raw input has held steady long enough.
	always_comb begin
		stable_next = stable_reg;
		db_next = 32'h0;
		hold_next = hold_reg;
		fired_next = fired_reg;
		short_next = 1'b0;
		long_next = 1'b0;
		if (i_sw != stable_reg) begin
			db_next = db_reg + 32'h1;
			if (db_reg >= 32'(DEBOUNCE_CYC - 1)) begin
				stable_next = i_sw;
				db_next = 32'h0;
			end
		end
		if (stable_reg) begin
			// The long action fires while still held, so the user sees it at four seconds.
			if (!fired_reg) begin
				hold_next = hold_reg + 32'h1;
				if (hold_reg >= 32'(LONG_CYC - 1)) begin
					long_next = 1'b1;
					fired_next = 1'b1;
				end
			end
		end else begin
			// Release before the threshold is a short press.
			if (hold_reg != 32'h0 && !fired_reg) begin
				short_next = 1'b1;
			end
			hold_next = 32'h0;
			fired_next = 1'b0;
		end
	end

	// Registers only.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			stable_reg <= 1'b0;
			db_reg <= 32'h0;
			hold_reg <= 32'h0;
			fired_reg <= 1'b0;
			short_reg <= 1'b0;
			long_reg <= 1'b0;
		end else begin
			stable_reg <= stable_next;
			db_reg <= db_next;
			hold_reg <= hold_next;
			fired_reg <= fired_next;
			short_reg <= short_next;
			long_reg <= long_next;
		end
	end
	assign o_short = short_reg;
	assign o_long = long_reg;
endmodule

// ===== pswc_checker.sv
// Port-level assertions for the power switch and wake controller.
// Assumes it is bound to the controller top and sees only its ports.
module pswc_checker
	import pswc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_standby_ok,
	input wire logic [2:0] i_os_cmd,
	input wire logic [2:0] o_pstate,
	input wire logic o_main_power,
	input wire logic o_cpu_power,
	input wire logic o_cold_boot,
	input wire logic o_wake_pulse,
	input wire logic o_sleep_req
);
	timeunit 1ns;
	timeprecision 100ps;
	// Everything runs on the one standby clock, so one default serves all checks.
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	reset_state_a: assert property ($rose(i_rst_n) |-> o_pstate == PST_G3 && !o_main_power)
		else $error("state not off after reset");
	main_follow_a: assert property (o_main_power == (o_pstate inside {PST_S0, PST_S1}))
		else $error("main power disagrees with state");
	cpu_off_a: assert property (o_pstate inside {PST_S3, PST_S4, PST_S5} |-> !o_cpu_power)
		else $error("processor powered in deep sleep");
	standby_loss_a: assert property (!i_standby_ok |=> o_pstate == PST_G3)
		else $error("no mechanical off on supply loss");
	cold_boot_a: assert property (o_cold_boot |-> $past(o_pstate) == PST_S5 && o_pstate == PST_S0)
		else $error("cold boot pulse outside soft-off exit");
	wake_from_a: assert property (o_wake_pulse |-> o_pstate == PST_S0 &&
		$past(o_pstate) inside {PST_S1, PST_S3, PST_S4, PST_S5})
		else $error("wake pulse from a wrong state");
	soft_off_a: assert property (o_pstate == PST_S0 && i_os_cmd == CMD_S5 |=> !o_main_power)
		else $error("soft-off command kept main power");
	sleep_req_a: assert property (o_sleep_req |-> $past(o_pstate) == PST_S0 && o_pstate == PST_S3)
		else $error("sleep request without sleep entry");
endmodule
bind power_switch_wake_controller pswc_checker i_pswc_checker (.i_sys_clk, .i_rst_n, .i_standby_ok,
	.i_os_cmd, .o_pstate, .o_main_power, .o_cpu_power, .o_cold_boot, .o_wake_pulse, .o_sleep_req);

// ===== panel_switch_model.sv
// Behavioural front-panel switch: holds a press for a given count of cycles.
// Assumes the caller runs on the same standby clock as the controller.
module panel_switch_model (
	input wire logic i_sys_clk,
	output logic o_switch
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_switch = 1'b0;
	// Edges move 1 ns after the clock so the controller never samples a moving level.
	task automatic press(input int cyc);
		@(posedge i_sys_clk);
		#1 o_switch = 1'b1;
		repeat (cyc) @(posedge i_sys_clk);
		#1 o_switch = 1'b0;
	endtask
endmodule

// ===== power_switch_wake_controller_test.sv
// Self-checking bench for the power switch and wake controller.
// Assumes short debounce and long-press counts so the run stays brief.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module power_switch_wake_controller_test
	import pswc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {os_cmd_t cmd; logic s5en; logic [6:0] wk; pstate_t exp;} row_t;
	logic clk, rst_n, sby, sw, s5en, alt, ps2, usb, ser, rtc, pme, lan;
	logic pme_en, main, cpu, cold, wkp, sreq;
	logic [2:0] cmd, pst;
	int errors = 0, n_checks = 0, cyc = 0, seen = 0;
	// Wake bits are {alt, ps2, usb, rtc, serial, pme, lan}.
	row_t rows[16] = '{'{CMD_S1, 0, 7'h01, PST_S0}, '{CMD_S1, 0, 7'h02, PST_S0},
		'{CMD_S1, 0, 7'h08, PST_S1}, '{CMD_S1, 0, 7'h20, PST_S0}, '{CMD_S1, 0, 7'h10, PST_S1},
		'{CMD_S3, 0, 7'h10, PST_S0}, '{CMD_S3, 0, 7'h20, PST_S0}, '{CMD_S3, 0, 7'h08, PST_S0},
		'{CMD_S4, 0, 7'h20, PST_S4}, '{CMD_S4, 0, 7'h04, PST_S4}, '{CMD_S4, 0, 7'h60, PST_S0},
		'{CMD_S4, 0, 7'h08, PST_S0}, '{CMD_S5, 0, 7'h01, PST_S5}, '{CMD_S5, 1, 7'h01, PST_S0},
		'{CMD_S5, 1, 7'h02, PST_S0}, '{CMD_S5, 1, 7'h10, PST_S5}};
	power_switch_wake_controller #(.DEBOUNCE_CYC(4), .LONG_CYC(50)) i_power_switch_wake_controller (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_standby_ok(sby), .i_switch(sw), .i_os_cmd(cmd),
		.i_s5_wake_en(s5en), .i_pme_en(pme_en), .i_lan_wake(lan), .i_pme_wake(pme),
		.i_rtc_wake(rtc), .i_serial_wake(ser), .i_usb_wake(usb), .i_ps2_wake(ps2),
		.i_ps2_alt_prtscr(alt), .o_pstate(pst), .o_main_power(main), .o_cpu_power(cpu),
		.o_cold_boot(cold), .o_wake_pulse(wkp), .o_sleep_req(sreq));
	panel_switch_model i_panel_switch_model (.i_sys_clk(clk), .o_switch(sw));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// A hang is cut short well beyond the few hundred cycles the tests need.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			errors++;
			conclude();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Presents one wake vector for a single cycle, then lets the state settle.
	task automatic wake(input logic [6:0] w);
		{alt, ps2, usb, rtc, ser, pme, lan} = w;
		tick(1);
		{alt, ps2, usb, rtc, ser, pme, lan} = 7'h00;
		tick(2);
	endtask
	// Power cycles the standby rail, then an alarm brings the board up to working.
	task automatic to_s0();
		sby = 1'b0;
		tick(2);
		sby = 1'b1;
		tick(2);
		wake(7'h08);
	endtask
	task automatic os(input os_cmd_t c);
		cmd = c;
		tick(1);
		cmd = CMD_NONE;
		tick(1);
	endtask
	task automatic conclude();
		if (errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{rst_n, sby, cmd, s5en, alt, ps2, usb, ser, rtc, pme, lan} = '0;
		pme_en = 1'b1;
		tick(4);
		`CHK(pst, PST_G3)
		sby = 1'b1;
		rst_n = 1'b1;
		tick(2);
		`CHK(pst, PST_S5)
		foreach (rows[i]) begin
			s5en = rows[i].s5en;
			to_s0();
			`CHK(pst, PST_S0)
			os(rows[i].cmd);
			wake(rows[i].wk);
			`CHK(pst, rows[i].exp)
		end
		// Short press from soft-off powers on; short from working sleeps.
		s5en = 1'b0;
		to_s0();
		os(CMD_S5);
		i_panel_switch_model.press(20);
		tick(12);
		`CHK(pst, PST_S0)
		i_panel_switch_model.press(20);
		// The sleep request is a one-cycle pulse, so it is counted cycle by cycle.
		repeat (12) begin
			tick(1);
			if (sreq === 1'b1) seen++;
		end
		`CHK(seen, 1)
		`CHK(pst, PST_S3)
		// A long hold while sleeping or working forces soft-off, even after release.
		i_panel_switch_model.press(70);
		tick(12);
		`CHK(pst, PST_S5)
		to_s0();
		i_panel_switch_model.press(70);
		tick(12);
		`CHK(pst, PST_S5)
		// A LAN wake from soft-off with the option set raises both pulses and the supplies.
		s5en = 1'b1;
		tick(2);
		lan = 1'b1;
		tick(1);
		lan = 1'b0;
		`CHK(cold, 1'b1)
		`CHK(wkp, 1'b1)
		`CHK(main, 1'b1)
		`CHK(cpu, 1'b1)
		tick(1);
		`CHK(cold, 1'b0)
		`CHK(wkp, 1'b0)
		// With the PME enable off, a PME request from suspend is dropped.
		os(CMD_S3);
		`CHK(cpu, 1'b0)
		pme_en = 1'b0;
		wake(7'h02);
		`CHK(pst, PST_S3)
		pme_en = 1'b1;
		// Without standby supply no wake is acted on.
		sby = 1'b0;
		wake(7'h08);
		`CHK(pst, PST_G3)
		conclude();
	end
endmodule
